// >>> hw/high_speed_capture_port.sv
// High speed capture port: APB registers, sample snapshot and serial master.
//
// Chosen here: the address map and the APB register port.
module high_speed_capture_port
  import capture_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_host_active,
  input wire logic sample_update,
  input wire sample_set_t sample_in,
  input wire logic link_clk,
  output logic capture_serial_clock,
  output logic capture_data_out,
  output logic capture_select
);

  // Decode of the mapped register addresses
  function automatic logic addr_mapped(input logic [11:0] addr);
    if (addr == CHIP_SETUP_ADDR) begin
      return 1'b1;
    end else if (addr == CAPTURE_CFG_ADDR) begin
      return 1'b1;
    end else if (addr == CAPTURE_STATUS_ADDR) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction : addr_mapped

  // Last word index of a word set; 11 behaves as 00
  function automatic logic [3:0] set_last(input logic [1:0] wset);
    if (wset == WSET_WAVE) begin
      return WAVE_LAST;
    end else begin
      return ALL_LAST;
    end
  endfunction : set_last

  // First word index of a word set
  function automatic logic [3:0] set_first(input logic [1:0] wset);
    if (wset == WSET_POWER) begin
      return POWER_FIRST;
    end else begin
      return WAVE_FIRST;
    end
  endfunction : set_first

  // Sign extension of one measurement word
  function automatic logic [WORD_BITS-1:0] sext(input logic [SAMPLE_BITS-1:0] w);
    return {{(WORD_BITS - SAMPLE_BITS){w[SAMPLE_BITS-1]}}, w};
  endfunction : sext

  // ---------------- APB domain ----------------
  // Software visible state
  logic [7:0] chip_setup;
  capture_cfg_t cfg;

  // Bus decode helpers
  logic wr_acc;
  logic enable_eff;

  // Crossing toggles; done_ltog is driven from the link domain
  logic req_tog;
  logic done_ltog;
  logic done_meta;
  logic done_sync;
  logic busy;

  // Transfer counter shown in the status register
  logic [15:0] frame_count;

  // Snapshot held still for the link side while busy
  sample_set_t snap_words;
  capture_cfg_t snap_cfg;

  // Writes need the low byte lane; only bits 7:0 are stored
  assign wr_acc = psel & penable & pwrite & pstrb[0];
  // Port runs only with its bit set and the SPI host idle
  assign enable_eff = chip_setup[ENABLE_BIT] & ~spi_host_active;
  // A transfer is outstanding until the link hands the toggle back
  assign busy = req_tog ^ done_sync;

  // Slave always answers in the access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_mapped(paddr);

  // Chip setup register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chip_setup <= CHIP_SETUP_RESET;
    end else if (wr_acc && paddr == CHIP_SETUP_ADDR) begin
      chip_setup <= pwdata[7:0];
      // Setting the enable while SPI owns the pins keeps the old value
      if (pwdata[ENABLE_BIT] && spi_host_active) begin
        chip_setup[ENABLE_BIT] <= chip_setup[ENABLE_BIT];
      end
    end
  end

  // Capture configuration; reserved bits are dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= CAPTURE_CFG_RESET;
    end else if (wr_acc && paddr == CAPTURE_CFG_ADDR) begin
      cfg <= pwdata[5:0];
    end
  end

  // Read data registered in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= '0;
      if (paddr == CHIP_SETUP_ADDR) begin
        prdata[7:0] <= chip_setup;
      end else if (paddr == CAPTURE_CFG_ADDR) begin
        prdata[5:0] <= cfg;
      end else if (paddr == CAPTURE_STATUS_ADDR) begin
        prdata[STATUS_BUSY_BIT] <= busy;
        prdata[STATUS_EN_BIT] <= enable_eff;
        prdata[31:16] <= frame_count;
      end
    end
  end

  // Done toggle comes back from the link domain through two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_meta <= 1'b0;
      done_sync <= 1'b0;
    end else begin
      done_meta <= done_ltog;
      done_sync <= done_meta;
    end
  end

  // Snapshot on the sample update; a busy port skips the cycle, which
  // yields every second cycle when a transfer outlasts one period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_tog <= 1'b0;
      snap_words <= '0;
      snap_cfg <= CAPTURE_CFG_RESET;
      frame_count <= '0;
    end else if (sample_update && enable_eff && !busy) begin
      snap_words <= sample_in;
      snap_cfg <= cfg;
      req_tog <= ~req_tog;
      // Every accepted transfer is counted for software
      frame_count <= frame_count + 16'h0001;
    end
  end

  // ---------------- Link domain ----------------
  // Local reset and synchronisers
  logic rst_meta;
  logic lrstn;
  logic req_meta;
  logic req_s1;
  logic req_s2;
  logic en_meta;
  logic en_sync;
  logic pol_meta;
  logic cfg_pol_sync;
  logic start;

  // Serial clock divider
  logic [2:0] half_cnt;
  logic tick;

  // Sequencer state, frozen config and position in the set
  link_state_t state;
  capture_cfg_t lcfg;
  logic [3:0] word_idx;
  logic [3:0] last_idx;
  logic [4:0] bit_idx;
  logic [2:0] gap_cnt;
  logic [WORD_BITS-1:0] shifter;
  logic pkg_end;

  // Reset release is synchronised to the link clock
  always_ff @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      rst_meta <= 1'b0;
      lrstn <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      lrstn <= rst_meta;
    end
  end

  // Request toggle and enable level cross with two flops each
  // Only the second flop of each pair reads the first
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      req_meta <= 1'b0;
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      en_meta <= 1'b0;
      en_sync <= 1'b0;
    end else begin
      req_meta <= req_tog;
      req_s1 <= req_meta;
      req_s2 <= req_s1;
      en_meta <= enable_eff;
      en_sync <= en_meta;
    end
  end

  // One link cycle pulse per new request toggle
  assign start = req_s1 ^ req_s2;

  // Half period divider for the serial clock
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      half_cnt <= HALF_FAST - 3'h1;
    end else if (state == ST_IDLE || tick) begin
      // Rate comes from the frozen lcfg; the reload in idle still uses the previous transfer's
      half_cnt <= (lcfg.clock_slow ? HALF_SLOW : HALF_FAST) - 3'h1;
    end else begin
      half_cnt <= half_cnt - 3'h1;
    end
  end

  // Tick marks each half serial period while a transfer runs
  assign tick = (half_cnt == 3'h0) && (state != ST_IDLE);

  // Package boundary: 8-bit packages only matter with the gap on
  always_comb begin
    if (bit_idx == LAST_WORD_BIT) begin
      pkg_end = 1'b1;
    end else begin
      pkg_end = lcfg.package_byte && (bit_idx[2:0] == LAST_BYTE_BIT);
    end
  end

  // Transfer sequencer; the snapshot is stable until done toggles back
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      state <= ST_IDLE;
      lcfg <= CAPTURE_CFG_RESET;
      word_idx <= '0;
      last_idx <= '0;
      bit_idx <= '0;
      gap_cnt <= '0;
      shifter <= '0;
      capture_serial_clock <= 1'b1;
      capture_data_out <= 1'b1;
      done_ltog <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          capture_serial_clock <= 1'b1;
          capture_data_out <= 1'b1;
          // A disabled port hands the toggle straight back
          if (start && en_sync) begin
            // First word of the chosen set comes from the frozen snapshot
            lcfg <= snap_cfg;
            word_idx <= set_first(snap_cfg.word_set_select);
            last_idx <= set_last(snap_cfg.word_set_select);
            shifter <= sext(snap_words.word[set_first(snap_cfg.word_set_select)]);
            bit_idx <= '0;
            state <= ST_SEND;
          end else if (start) begin
            done_ltog <= ~done_ltog;
          end
        end

        ST_SEND: begin
          if (tick && capture_serial_clock) begin
            // Falling edge launches the next bit, MSB first
            capture_serial_clock <= 1'b0;
            capture_data_out <= shifter[WORD_BITS-1];
            shifter <= {shifter[WORD_BITS-2:0], 1'b0};
          end else if (tick) begin
            // Rising edge: the receiver samples here, the bit is counted
            capture_serial_clock <= 1'b1;
            bit_idx <= bit_idx + 5'h01;
            // Word done: stop after the last one, else load the next
            if (bit_idx == LAST_WORD_BIT) begin
              if (word_idx == last_idx) begin
                state <= ST_IDLE;
                done_ltog <= ~done_ltog;
              end else begin
                word_idx <= word_idx + 4'h1;
                shifter <= sext(snap_words.word[word_idx + 4'h1]);
              end
            end
            // Gaps only between packages, never after the final bit
            if (lcfg.package_gap_enable && pkg_end && !(bit_idx == LAST_WORD_BIT && word_idx == last_idx)) begin
              gap_cnt <= '0;
              state <= ST_GAP;
            end
          end
        end

        ST_GAP: begin
          // Clock keeps running through the gap, data holds
          if (tick) begin
            capture_serial_clock <= ~capture_serial_clock;
            if (!capture_serial_clock) begin
              gap_cnt <= gap_cnt + 3'h1;
              // The seventh gap cycle ends on a rising edge
              if (gap_cnt == GAP_CYCLES - 3'h1) begin
                state <= ST_SEND;
              end
            end
          end
        end

        // An illegal code falls back to idle
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Select pin: high when off, else idle/gap and package levels by polarity
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      capture_select <= 1'b1;
    end else if (!en_sync && state == ST_IDLE) begin
      capture_select <= 1'b1;
    end else if (state == ST_SEND) begin
      capture_select <= lcfg.select_polarity;
    end else if (state == ST_GAP) begin
      capture_select <= ~lcfg.select_polarity;
    end else begin
      capture_select <= ~cfg_pol_sync;
    end
  end

  // Idle polarity follows the live setting through two flops
  always_ff @(posedge link_clk or negedge lrstn) begin
    if (!lrstn) begin
      pol_meta <= 1'b0;
      cfg_pol_sync <= 1'b0;
    end else begin
      pol_meta <= cfg.select_polarity;
      cfg_pol_sync <= pol_meta;
    end
  end

endmodule : high_speed_capture_port

// >>> inc/capture_pkg.sv
// Constants, types and register map of the high speed capture port.
package capture_pkg;
  // Register byte addresses on APB
  localparam logic [11:0] CHIP_SETUP_ADDR = 12'h000;
  localparam logic [11:0] CAPTURE_CFG_ADDR = 12'h004;
  localparam logic [11:0] CAPTURE_STATUS_ADDR = 12'h008;
  // Reset values
  localparam logic [7:0] CHIP_SETUP_RESET = 8'h00;
  localparam logic [5:0] CAPTURE_CFG_RESET = 6'h00;
  // Field positions
  localparam int unsigned ENABLE_BIT = 6;
  localparam int unsigned STATUS_BUSY_BIT = 0;
  localparam int unsigned STATUS_EN_BIT = 1;
  // Word geometry
  localparam int unsigned NUM_WORDS = 16;
  localparam int unsigned SAMPLE_BITS = 24;
  localparam int unsigned WORD_BITS = 32;
  localparam logic [4:0] LAST_WORD_BIT = 5'h1f;
  localparam logic [2:0] LAST_BYTE_BIT = 3'h7;
  localparam logic [2:0] GAP_CYCLES = 3'h7;
  // Word sets: index ranges into the sample set
  localparam logic [1:0] WSET_WAVE = 2'h1;
  localparam logic [1:0] WSET_POWER = 2'h2;
  localparam logic [3:0] WAVE_FIRST = 4'h0;
  localparam logic [3:0] WAVE_LAST = 4'h6;
  localparam logic [3:0] POWER_FIRST = 4'h7;
  localparam logic [3:0] ALL_LAST = 4'hf;
  // Serial clock timing, derived from the link clock period
  localparam int unsigned LINK_PERIOD_PS = 32000;
  localparam int unsigned FAST_PERIOD_PS = 125000;
  localparam int unsigned SLOW_PERIOD_PS = 250000;
  localparam logic [2:0] HALF_FAST = 3'((FAST_PERIOD_PS + 2 * LINK_PERIOD_PS - 1) / (2 * LINK_PERIOD_PS));
  localparam logic [2:0] HALF_SLOW = 3'((SLOW_PERIOD_PS + 2 * LINK_PERIOD_PS - 1) / (2 * LINK_PERIOD_PS));
  // Configuration layout, bit 0 at the bottom
  typedef struct packed {
    logic select_polarity;
    logic [1:0] word_set_select;
    logic package_gap_enable;
    logic package_byte;
    logic clock_slow;
  } capture_cfg_t;
  // Measurement words in transmit order, currents and voltages then powers
  typedef struct packed {
    logic [NUM_WORDS-1:0][SAMPLE_BITS-1:0] word;
  } sample_set_t;
  // Link state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_GAP = 3'b100
  } link_state_t;
endpackage : capture_pkg

// >>> sim/capture_receiver.sv
// Serial slave model that collects the capture stream.
module capture_receiver (
  input wire logic serial_clock,
  input wire logic data_in,
  input wire logic select_in,
  input wire logic active_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic bits[$];
  int pkgs;
  int gap_edges;
  time t_first;
  time t_last;
  // Sample on rising edges; edges while deselected are gap cycles
  always @(posedge serial_clock) begin
    if (select_in === active_level) begin
      if (bits.size() == 0) t_first = $time;
      t_last = $time;
      bits.push_back(data_in);
    end else begin
      gap_edges++;
    end
  end
  // Every move to the active level opens a package
  always @(select_in) begin
    if (select_in === active_level) pkgs++;
  end
  task automatic clear();
    bits.delete();
    pkgs = 0;
    gap_edges = 0;
  endtask : clear
endmodule : capture_receiver

// >>> sim/capture_port_props.sv
// Checker of capture port pin shape and bus answers.
module capture_port_props
  import capture_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic link_clk,
  input wire logic capture_serial_clock,
  input wire logic capture_data_out,
  input wire logic capture_select
);
  a_pins_after_reset: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(presetn) |-> capture_data_out && capture_select) else $error("pins low after reset");
  // Edges right after reset compare against unknown history, so they are skipped
  a_data_on_fall: assert property (@(posedge link_clk) disable iff (!presetn)
    $past(presetn) && $rose(capture_serial_clock) |-> $stable(capture_data_out)) else $error("data moved on rise");
  a_low_min: assert property (@(posedge link_clk) disable iff (!presetn)
    $fell(capture_serial_clock) |=> !capture_serial_clock) else $error("clock low too short");
  a_low_bound: assert property (@(posedge link_clk) disable iff (!presetn)
    $fell(capture_serial_clock) |-> ##[2:4] capture_serial_clock) else $error("clock low too long");
  a_high_min: assert property (@(posedge link_clk) disable iff (!presetn)
    $rose(capture_serial_clock) |=> capture_serial_clock) else $error("clock high too short");
  a_select_steady: assert property (@(posedge link_clk) disable iff (!presetn)
    $past(presetn) && $rose(capture_serial_clock) |-> $stable(capture_select)) else $error("select moved on rise");
  a_ready_always: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable |-> pready) else $error("wait state seen");
  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && paddr > CAPTURE_STATUS_ADDR |-> pslverr) else $error("no error flag");
  a_cfg_no_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && paddr == CAPTURE_CFG_ADDR |-> !pslverr) else $error("false error flag");
  // Main traffic seen
  c_sel_fall: cover property (@(posedge link_clk) $fell(capture_select));
  c_sel_rise: cover property (@(posedge link_clk) $rose(capture_select));
  c_bus_err: cover property (@(posedge pclk) pslverr);
endmodule : capture_port_props
bind high_speed_capture_port capture_port_props i_capture_port_props (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .link_clk(link_clk), .capture_serial_clock(capture_serial_clock),
  .capture_data_out(capture_data_out), .capture_select(capture_select));

// >>> sim/tb_high_speed_capture_port.sv
// Self-checking bench of the high speed capture port.
module tb_high_speed_capture_port
  import capture_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic link_clk = 1'b0;
  logic presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic spi_host_active = 1'b0;
  logic sample_update = 1'b0;
  sample_set_t sample_in = '0;
  logic pol = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, sclk, sdo, sel;
  int err_total = 0;
  int comparisons = 0;
  // Link clock never shares a rising edge with pclk
  always #5 pclk = ~pclk;
  always #16 link_clk = ~link_clk;
  high_speed_capture_port i_high_speed_capture_port (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .spi_host_active(spi_host_active), .sample_update(sample_update),
    .sample_in(sample_in), .link_clk(link_clk), .capture_serial_clock(sclk), .capture_data_out(sdo),
    .capture_select(sel));
  capture_receiver i_capture_receiver (.serial_clock(sclk), .data_in(sdo), .select_in(sel),
    .active_level(pol));
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n <= 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
      if (n == 20) begin
        err_total++;
        finish_test();
      end
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Odd words negative so sign extension shows; alt gives later samples
  function automatic logic [23:0] val(input int i, input logic alt);
    return {i[0], 7'(i), 16'h5a3c} ^ {24{alt}};
  endfunction : val
  task automatic pulse_update();
    sample_update <= 1'b1;
    @(posedge pclk);
    sample_update <= 1'b0;
  endtask : pulse_update
  task automatic test_reset();
    check({29'h0, sclk, sdo, sel}, 32'h0000_0007);
    apb(1'b0, CHIP_SETUP_ADDR, 32'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, CAPTURE_STATUS_ADDR, 32'h0);
    check(rd & 32'h0000_0002, 32'h0000_0000);
    apb(1'b0, 12'h00c, 32'h0);
    check({rd[30:0], er}, 32'h0000_0001);
    $display("test reset done");
  endtask : test_reset
  task automatic run_transfer(input logic [7:0] cfg, input int first, input int last);
    int nbits;
    int k;
    int pk;
    int gaps;
    logic [23:0] v;
    logic [31:0] got;
    nbits = (last - first + 1) * 32;
    pk = cfg[2] ? (cfg[1] ? nbits / 8 : nbits / 32) : 1;
    gaps = (pk - 1) * 7;
    for (int i = 0; i < 16; i++) sample_in.word[i] <= val(i, 1'b0);
    apb(1'b1, CAPTURE_CFG_ADDR, {24'h0, cfg});
    pol <= cfg[5];
    apb(1'b0, CAPTURE_CFG_ADDR, 32'h0);
    check(rd, {26'h0, cfg[5:0]});
    apb(1'b1, CHIP_SETUP_ADDR, 32'h0000_0040);
    apb(1'b0, CAPTURE_STATUS_ADDR, 32'h0);
    check(rd & 32'h0000_0002, 32'h0000_0002);
    repeat (20) @(posedge pclk);
    i_capture_receiver.clear();
    pulse_update();
    for (int i = 0; i < 16; i++) sample_in.word[i] <= val(i, 1'b1);
    repeat (100) @(posedge pclk);
    pulse_update();
    k = 0;
    while (i_capture_receiver.bits.size() < nbits && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    if (k == 40000) begin
      err_total++;
      finish_test();
    end
    repeat (500) @(posedge pclk);
    check(32'(i_capture_receiver.bits.size()), 32'(nbits));
    check(32'(i_capture_receiver.pkgs), 32'(pk));
    check(32'(i_capture_receiver.gap_edges), 32'(gaps * cfg[2]));
    check(32'(i_capture_receiver.t_last - i_capture_receiver.t_first),
      32'((nbits - 1 + gaps * cfg[2]) * (cfg[0] ? 256 : 128)));
    for (int i = first; i <= last; i++) begin
      v = val(i, 1'b0);
      for (int b = 0; b < 32; b++) got = {got[30:0], i_capture_receiver.bits[(i - first) * 32 + b]};
      check(got, {{8{v[23]}}, v});
    end
    apb(1'b1, CHIP_SETUP_ADDR, 32'h0);
    $display("test transfer %h done", cfg);
  endtask : run_transfer
  // Fast transfers fit one sample period and go out on every update
  task automatic test_rate();
    int k;
    apb(1'b1, CAPTURE_CFG_ADDR, 32'h0);
    pol <= 1'b0;
    apb(1'b1, CHIP_SETUP_ADDR, 32'h0000_0040);
    repeat (20) @(posedge pclk);
    i_capture_receiver.clear();
    pulse_update();
    repeat (12499) @(posedge pclk);
    check(32'(i_capture_receiver.bits.size()), 32'h0000_0200);
    pulse_update();
    k = 0;
    while (i_capture_receiver.bits.size() < 1024 && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20000) begin
      err_total++;
      finish_test();
    end
    repeat (500) @(posedge pclk);
    check(32'(i_capture_receiver.bits.size()), 32'h0000_0400);
    apb(1'b1, CHIP_SETUP_ADDR, 32'h0);
    $display("test rate done");
  endtask : test_rate
  task automatic test_spi_block();
    spi_host_active <= 1'b1;
    apb(1'b1, CHIP_SETUP_ADDR, 32'h0000_0040);
    apb(1'b0, CHIP_SETUP_ADDR, 32'h0);
    check(rd & 32'h0000_0040, 32'h0000_0000);
    i_capture_receiver.clear();
    pulse_update();
    repeat (2000) @(posedge pclk);
    check(32'(i_capture_receiver.bits.size()), 32'h0000_0000);
    apb(1'b0, CAPTURE_STATUS_ADDR, 32'h0);
    check(rd & 32'hffff_0003, 32'h0006_0000);
    spi_host_active <= 1'b0;
    $display("test spi block done");
  endtask : test_spi_block
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    run_transfer(8'h00, 0, 15);
    run_transfer(8'hed, 0, 6);
    run_transfer(8'h16, 7, 15);
    run_transfer(8'h19, 0, 15);
    test_rate();
    test_spi_block();
    finish_test();
  end
endmodule : tb_high_speed_capture_port
